//--- charge_mode_regs.vh
/*
 * Constants of the USB charge-mode controller: register offsets,
 * field positions, reset values, mode codes and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CHARGE_MODE_REGS_VH
`define CHARGE_MODE_REGS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define CTRL_RESET 32'h0000_0001
`define CTRL_DATA_ALLOW 0
`define CTRL_RESCAN 1

// Status field positions
`define ST_DCP_LO 0
`define ST_DCP_HI 1
`define ST_MODE_LO 2
`define ST_MODE_HI 4
`define ST_DATA_SW 5
`define ST_PWR_SW 6
`define ST_DISCHG 7
`define ST_FAULT_N 8
`define ST_STATUS_N 9
`define ST_EN 10
`define ST_OVERCUR 11

// ----------------------------------------------------------------
// Mode classes and detection states
// ----------------------------------------------------------------
`define CLS_DCP 2'h0
`define CLS_SDP 2'h1
`define CLS_CLIENT 2'h2
`define CLS_CDP 2'h3
`define DCP_HIGH_BIAS 2'h0
`define DCP_BRIEF_12V 2'h1
`define DCP_SHORTED 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define T_BRIEF_12V 20'h09c40 // 1000 us at 40 MHz
`define T_DISCHARGE 20'h04e20 // 500 us at 40 MHz
`define TIMER_W 20

`endif

//--- sync3.v
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to mclk; the output follows once
 * the second and third stages agree.
 */
`default_nettype none

module sync3 #(
    parameter RST = 1'b0
) (
    // Clock, reset, enable
    input wire mclk,
    input wire arst_n,
    input wire ce,
    // Data
    input wire din,
    output reg dout
);

reg s1_r;
reg s2_r;
reg s3_r;

// Stage chain; s1_r feeds only s2_r
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        s1_r <= RST;
        s2_r <= RST;
        s3_r <= RST;
        dout <= RST;
    end
    else if (ce)
    begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r)
            dout <= s3_r; // Only a settled level counts
    end
end

endmodule

`default_nettype wire

//--- hold_timer.v
/*
 * One-shot interval timer: start loads LEN cycles, busy stands while
 * counting, done pulses one cycle at the end. Abort cancels silently.
 * Assumes start and abort come from logic on mclk.
 */
`default_nettype none

module hold_timer #(
    parameter W = 20,
    parameter [W-1:0] LEN = {{(W-1){1'b0}}, 1'b1}
) (
    // Clock, reset, enable
    input wire mclk,
    input wire arst_n,
    input wire ce,
    // Control
    input wire start,
    input wire abort,
    // Status
    output reg busy,
    output reg done
);

reg [W-1:0] cnt_r;

// Countdown; a restart while busy reloads the full interval
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        cnt_r <= {W{1'b0}};
        busy <= 1'b0;
        done <= 1'b0;
    end
    else if (ce)
    begin
        done <= 1'b0;
        if (abort)
        begin
            busy <= 1'b0;
            cnt_r <= {W{1'b0}};
        end
        else if (start)
        begin
            busy <= 1'b1;
            cnt_r <= LEN;
        end
        else if (busy)
        begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1})
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule

`default_nettype wire

//--- usb_charge_mode_controller.v
/*
 * USB charging-port mode controller: mode decode, dedicated-charging
 * auto-detect machine, data-line and power switch gating, and an
 * AXI4-Lite register slave.
 * Assumes analog front ends report attach/release and overcurrent as
 * levels asynchronous to mclk, and that the AXI master runs on mclk.
 */
// Function
// R1 - Only one dedicated-charging state: automatic, machine picks shorted/high-bias/1.2 V
// R2 - Entering dedicated charging, detection starts in the high-bias scheme
// R3 - High-bias scheme drives both data lines to the 2.7 V bias
// R4 - A high-bias compatible device keeps the machine in high-bias
// R5 - BC1.2 device: power back on without discharge, brief 1.2 V, then shorted
// R6 - 1.2 V scheme shorts lines, pulls to 1.2 V for fixed time
// R7 - Shorted scheme joins D+ and D- through at most 200 ohms
// R8 - Shorted held until data line released, then back to high-bias
// R9 - Client mode: power switch off, data switches on
// R10 - Data switches close in CDP, SDP or client mode when enabled (code also needs the CTRL data-allow bit set)
// R11 - Data switches enabled only while enable input is high
// R12 - In CDP data switches stay closed, even during handshake
// R13 - Data switches open when enable low or in dedicated charging
// R14 - Current limit alone never opens the data switches
// R15 - Data switches open while the output is being discharged
// R16 - Portable device drives 0.6 V on D+, senses D- for port type
// R17 - Portable device drives 0.6 V on D-, senses D+ for CDP or DCP
// R18 - Decode three mode inputs into the six modes; follow every change
// R19 - No discharge on 000/001 or 110/111 changes
// R20 - Fault suppressed in 000 and 110; status and fault off in client
// R21 - Mode and enable inputs synchronised before decoding
// R22 - Reset: switches open, detection machine in high-bias
`include "charge_mode_regs.vh"
`default_nettype none

module usb_charge_mode_controller #(
    parameter [`TIMER_W-1:0] BRIEF_12V_CYC = `T_BRIEF_12V,
    parameter [`TIMER_W-1:0] DISCHARGE_CYC = `T_DISCHARGE
) (
    // Clock, reset, enable
    input wire mclk,
    input wire arst_n,
    input wire ce,
    // Mode and enable pins
    input wire mode_select_bit0,
    input wire mode_select_bit1,
    input wire mode_select_bit2,
    input wire port_enable,
    // Analog front-end indications
    input wire bc12_attach_det,
    input wire dline_released,
    input wire overcurrent,
    // Switch and bias controls
    output reg pwr_sw_on,
    output reg data_sw_on,
    output reg discharge_on,
    output reg ilim_high,
    output reg high_bias_scheme,
    output reg brief_12v_on,
    output reg dline_short_on,
    output reg status_n,
    output reg fault_n,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [3:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [3:0] s_axi_araddr,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp
);

// -------------------------------
// Input synchronisers
// -------------------------------
wire [2:0] code_s;
wire en_s;
wire bc12_s;
wire rel_s;
wire oc_s;

// Mode pins and enable settle before decode [R21]
sync3 u_sync_m0 (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(mode_select_bit0),
    .dout(code_s[2]));
sync3 u_sync_m1 (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(mode_select_bit1),
    .dout(code_s[1]));
sync3 u_sync_m2 (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(mode_select_bit2),
    .dout(code_s[0]));
sync3 u_sync_en (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(port_enable),
    .dout(en_s));
sync3 u_sync_bc (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(bc12_attach_det),
    .dout(bc12_s));
sync3 u_sync_rl (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(dline_released),
    .dout(rel_s));
sync3 u_sync_oc (.mclk(mclk), .arst_n(arst_n), .ce(ce), .din(overcurrent),
    .dout(oc_s));

// -------------------------------
// Mode decode
// -------------------------------
reg [1:0] cls;
reg hi_lim;

// Code is {bit0, bit1, bit2}; don't-care bits fold together [R18]
always @*
begin
    cls = `CLS_DCP;
    hi_lim = 1'b0;
    case (code_s)
        3'h0: cls = `CLS_DCP;
        3'h1:
        begin
            cls = `CLS_DCP;
            hi_lim = 1'b1;
        end
        3'h2, 3'h3: cls = `CLS_SDP;
        3'h4, 3'h5: cls = `CLS_CLIENT;
        3'h6: cls = `CLS_SDP;
        3'h7:
        begin
            cls = `CLS_CDP;
            hi_lim = 1'b1;
        end
        default: cls = `CLS_DCP;
    endcase
end

// -------------------------------
// Mode change tracking and output discharge
// -------------------------------
reg [2:0] code_r;
reg [1:0] cls_r;
reg hi_lim_r;
wire key_change;
wire pair_exempt;
wire dis_start;
wire dis_busy;

// Pairs sharing bit0 and bit1, 000/001 and 110/111, skip the discharge [R19]
assign key_change = (cls != cls_r) || (hi_lim != hi_lim_r);
assign pair_exempt = (code_r[2:1] == code_s[2:1]) &&
    ((code_s[2:1] == 2'h0) || (code_s[2:1] == 2'h3));
assign dis_start = key_change && !pair_exempt;

// Previous mode, so each change is seen once
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        code_r <= 3'h0;
        cls_r <= `CLS_DCP;
        hi_lim_r <= 1'b0;
    end
    else if (ce)
    begin
        code_r <= code_s;
        cls_r <= cls;
        hi_lim_r <= hi_lim;
    end
end

hold_timer #(.W(`TIMER_W), .LEN(DISCHARGE_CYC)) u_dis_tmr (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .start(dis_start),
    .abort(1'b0),
    .busy(dis_busy),
    .done()
);

// -------------------------------
// Dedicated-charging auto-detect machine
// -------------------------------
localparam [1:0] ST_HB = `DCP_HIGH_BIAS;
localparam [1:0] ST_12 = `DCP_BRIEF_12V;
localparam [1:0] ST_SH = `DCP_SHORTED;

reg [1:0] dcp_r;
reg [1:0] dcp_nxt;
reg rescan_r;
wire in_dcp;
wire t12_start;
wire t12_done;

assign in_dcp = (cls == `CLS_DCP) && en_s && !dis_busy;
assign t12_start = in_dcp && (dcp_r == ST_HB) && bc12_s;

// One automatic state only; outside it the machine waits in high-bias [R1]
always @*
begin
    dcp_nxt = dcp_r;
    if (!in_dcp || rescan_r)
        dcp_nxt = ST_HB; // Every entry starts in high-bias [R2]
    else
    begin
        case (dcp_r)
            ST_HB:
                if (bc12_s)
                    dcp_nxt = ST_12; // BC1.2 device seen [R5]
                else
                    dcp_nxt = ST_HB; // Compatible device stays here [R4]
            ST_12:
                if (t12_done)
                    dcp_nxt = ST_SH; // Fixed interval over [R6]
            ST_SH:
                if (rel_s)
                    dcp_nxt = ST_HB; // Line released [R8]
            default: dcp_nxt = ST_HB;
        endcase
    end
end

// State register; reset lands in high-bias [R22]
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
        dcp_r <= ST_HB;
    else if (ce)
        dcp_r <= dcp_nxt;
end

hold_timer #(.W(`TIMER_W), .LEN(BRIEF_12V_CYC)) u_t12_tmr (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .start(t12_start),
    .abort(!in_dcp || rescan_r),
    .busy(),
    .done(t12_done)
);

// -------------------------------
// Register file
// -------------------------------
reg data_allow_r;
wire [31:0] status_word;

assign status_word = {20'h0, oc_s, en_s, status_n, fault_n, discharge_on,
    pwr_sw_on, data_sw_on, code_s, dcp_r};

// -------------------------------
// Switch, bias and indicator outputs
// -------------------------------
// All registered; overcurrent deliberately absent from data gating [R14]
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        pwr_sw_on <= 1'b0; // Switches open out of reset [R22]
        data_sw_on <= 1'b0;
        discharge_on <= 1'b0;
        ilim_high <= 1'b0;
        high_bias_scheme <= 1'b0;
        brief_12v_on <= 1'b0;
        dline_short_on <= 1'b0;
        status_n <= 1'b1;
        fault_n <= 1'b1;
    end
    else if (ce)
    begin
        discharge_on <= dis_busy;
        // Client keeps power off; dedicated power stays on through 1.2 V [R9] [R5]
        pwr_sw_on <= en_s && !dis_busy && (cls != `CLS_CLIENT);
        // Data path: enable high, not dedicated, not discharging [R10] [R11] [R13] [R15]
        // CDP has no handshake exception, so switches stay closed [R12]
        data_sw_on <= en_s && !dis_busy && (cls != `CLS_DCP) && data_allow_r;
        ilim_high <= hi_lim;
        high_bias_scheme <= in_dcp && (dcp_nxt == ST_HB); // 2.7 V on both [R3]
        brief_12v_on <= in_dcp && (dcp_nxt == ST_12); // Short plus 1.2 V [R6]
        // 200 ohm tie in both 1.2 V and shorted phases [R7]
        dline_short_on <= in_dcp && ((dcp_nxt == ST_12) || (dcp_nxt == ST_SH));
        // Indicators silent in client, fault muted in 000 and 110 [R20]
        status_n <= !(hi_lim && (cls != `CLS_CLIENT));
        fault_n <= !(oc_s && (cls != `CLS_CLIENT) && (code_s != 3'h0) &&
            (code_s != 3'h6));
    end
end

// -------------------------------
// AXI4-Lite write channel
// -------------------------------
reg aw_got_r;
reg w_got_r;
reg [3:0] aw_addr_r;
reg [31:0] w_data_r;
reg w_strb0_r;

// Address and data may arrive in either order; response after both
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        aw_addr_r <= 4'h0;
        w_data_r <= 32'h0;
        w_strb0_r <= 1'b0;
        data_allow_r <= 1'b1;
        rescan_r <= 1'b0;
    end
    else if (ce)
    begin
        rescan_r <= 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb0_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end
        if (aw_got_r && w_got_r && !s_axi_bvalid)
        begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r == `ADDR_CTRL)
            begin
                s_axi_bresp <= 2'h0;
                if (w_strb0_r)
                begin
                    data_allow_r <= w_data_r[`CTRL_DATA_ALLOW];
                    rescan_r <= w_data_r[`CTRL_RESCAN];
                end
            end
            else if (aw_addr_r == `ADDR_STATUS)
                s_axi_bresp <= 2'h0; // Read-only, write ignored
            else
                s_axi_bresp <= 2'h2; // Unmapped: SLVERR
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// -------------------------------
// AXI4-Lite read channel
// -------------------------------
// One read at a time; arready drops until the data is taken
always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h0;
    end
    else if (ce)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `ADDR_CTRL: s_axi_rdata <= {31'h0, data_allow_r};
                `ADDR_STATUS: s_axi_rdata <= status_word;
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

`default_nettype wire

//--- usb_charge_mode_controller_checker.sv
/*
 Port checker for the charge-mode controller.
 Assumes ce held high and the bench's short brief 1.2 V interval of 8.
*/
`default_nettype none
module usb_charge_mode_controller_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Pins
    input wire logic mode_select_bit0,
    input wire logic mode_select_bit1,
    input wire logic port_enable,
    // Switch controls
    input wire logic pwr_sw_on,
    input wire logic data_sw_on,
    input wire logic discharge_on,
    input wire logic ilim_high,
    input wire logic high_bias_scheme,
    input wire logic brief_12v_on,
    input wire logic dline_short_on,
    input wire logic status_n,
    input wire logic fault_n,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // -------------------------------
    // Pin classes
    // -------------------------------
    // Raw pins, so all checks but a_brief_length wait out the synchroniser first
    wire logic dcp_pin = !mode_select_bit0 && !mode_select_bit1;
    wire logic client_pin = mode_select_bit0 && !mode_select_bit1;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    a_enable_gates: assert property (!port_enable [*8] |-> !data_sw_on)
        else $error("data switch closed with enable low");
    a_dcp_data_off: assert property (dcp_pin [*8] |-> !data_sw_on)
        else $error("data switch closed in dedicated mode");
    a_client_power: assert property (client_pin [*8] |->
        !pwr_sw_on && status_n && fault_n)
        else $error("client mode powers port or flags");
    a_discharge_data: assert property (discharge_on |-> !data_sw_on)
        else $error("data switch closed during discharge");
    a_bias_excl: assert property (high_bias_scheme |->
        !dline_short_on && !brief_12v_on)
        else $error("bias and short together");
    a_brief_shorted: assert property (brief_12v_on |->
        dline_short_on && pwr_sw_on && !discharge_on)
        else $error("brief phase not shorted or unpowered");
    a_brief_length: assert property ($rose(brief_12v_on) && dcp_pin |->
        brief_12v_on [*7] ##[1:3] (!brief_12v_on && dline_short_on))
        else $error("brief phase length wrong");
    a_limit_status: assert property (status_n == !ilim_high)
        else $error("status does not follow high limit");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
endmodule
bind usb_charge_mode_controller usb_charge_mode_controller_checker i_chk (
    .mclk, .arst_n, .mode_select_bit0, .mode_select_bit1, .port_enable, .pwr_sw_on,
    .data_sw_on, .discharge_on, .ilim_high, .high_bias_scheme, .brief_12v_on,
    .dline_short_on, .status_n, .fault_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

//--- portable_device_model.sv
/*
 Model of a handset plugged into the charging port.
 Assumes the bench sets attach and device kind on mclk.
*/
`default_nettype none
module portable_device_model #(
    parameter int LAT = 1
) (
    // Clock
    input wire logic mclk,
    // Bench commands
    input wire logic attached,
    input wire logic is_bc12,
    // Indications toward the port
    output logic bc12_attach_det,
    output logic dline_released
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] att_q = '0;
    logic [7:0] bc_q = '0;
    // Delay line: a slow handset answers late
    always @(posedge mclk)
    begin
        att_q <= {att_q[6:0], attached};
        bc_q <= {bc_q[6:0], attached && is_bc12};
    end
    assign bc12_attach_det = bc_q[LAT-1];
    assign dline_released = !att_q[LAT-1];
endmodule
`default_nettype wire

//--- test_usb_charge_mode_controller.sv
/*
 Self-checking bench for the charge-mode controller.
 Assumes the bound checker and the handset model beside the block.
*/
`default_nettype none
module test_usb_charge_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BRIEF = 8;
    localparam int DIS = 5;
    logic mclk = '0, arst_n = '0, ce = '1, port_enable = '0, overcurrent = '0;
    logic mode_select_bit0 = '0, mode_select_bit1 = '0, mode_select_bit2 = '0;
    logic attached = '0, is_bc12 = '0, bc12_attach_det, dline_released;
    logic pwr_sw_on, data_sw_on, discharge_on, ilim_high, high_bias_scheme;
    logic brief_12v_on, dline_short_on, status_n, fault_n;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors = 0;
    int n_compared = 0;
    // Short counts keep the run brief
    usb_charge_mode_controller #(.BRIEF_12V_CYC(20'h8), .DISCHARGE_CYC(20'h5))
    i_usb_charge_mode_controller (.mclk, .arst_n, .ce, .mode_select_bit0, .mode_select_bit1,
        .mode_select_bit2, .port_enable, .bc12_attach_det, .dline_released, .overcurrent,
        .pwr_sw_on, .data_sw_on, .discharge_on, .ilim_high, .high_bias_scheme, .brief_12v_on,
        .dline_short_on, .status_n, .fault_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    portable_device_model #(.LAT(3)) i_portable_device_model (.mclk, .attached, .is_bc12,
        .bc12_attach_det, .dline_released);
    initial forever #12.5 mclk = ~mclk;
    // -------------------------------
    // Shared tasks
    // -------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 50)
        begin
            cmp("wait", 1, 0);
            stop_test;
        end
    endtask
    // Pins settle through the synchroniser and any discharge
    task automatic set_mode(input logic [2:0] c, input logic en);
        @(posedge mclk);
        {mode_select_bit0, mode_select_bit1, mode_select_bit2} <= c;
        port_enable <= en;
        repeat (20) @(posedge mclk);
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge mclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 50);
        tmo(n);
        s_axi_bready <= 1'h0;
        cmp("bresp", er, s_axi_bresp);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        int n = 0;
        @(posedge mclk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        do
        begin
            @(posedge mclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 50);
        tmo(n);
        s_axi_rready <= 1'h0;
        cmp("rresp", er, s_axi_rresp);
        cmp("rdata", e, s_axi_rdata & m);
    endtask
    // -------------------------------
    // Scenarios
    // -------------------------------
    task automatic t_regs;
        axi_rd(4'h0, 32'h1, 32'h1, 2'h0);
        axi_rd(4'h4, 32'h3, 32'h0, 2'h0);
        axi_rd(4'h8, 32'hffffffff, 32'h0, 2'h2);
        axi_wr(4'hc, 32'h0, 2'h2);
        axi_wr(4'h4, 32'h0, 2'h0);
    endtask
    task automatic t_modes;
        logic dcp, cl, hi;
        for (int c = 0; c < 8; c++)
        begin
            set_mode(c[2:0], 1'h1);
            dcp = c < 2;
            cl = c[2:1] == 2'h2;
            hi = c == 1 || c == 7;
            cmp("data_sw_on", !dcp, data_sw_on);
            cmp("pwr_sw_on", !cl, pwr_sw_on);
            cmp("ilim_high", hi, ilim_high);
            cmp("status_n", !hi, status_n);
            axi_rd(4'h4, 32'h1c, c << 2, 2'h0);
        end
    endtask
    task automatic t_enable;
        set_mode(3'h3, 1'h0);
        cmp("data_sw_on", 0, data_sw_on);
        set_mode(3'h3, 1'h1);
        cmp("data_sw_on", 1, data_sw_on);
        axi_wr(4'h0, 32'h0, 2'h0);
        repeat (2) @(posedge mclk);
        cmp("data_sw_on", 0, data_sw_on);
        axi_wr(4'h0, 32'h1, 2'h0);
        repeat (2) @(posedge mclk);
        cmp("data_sw_on", 1, data_sw_on);
    endtask
    task automatic move(input logic [2:0] c, input logic ed);
        int len = 0;
        logic bad = 1'h0;
        @(posedge mclk);
        {mode_select_bit0, mode_select_bit1, mode_select_bit2} <= c;
        repeat (30)
        begin
            @(posedge mclk);
            if (discharge_on === 1'h1) len++;
            if (discharge_on === 1'h1 && data_sw_on !== 1'h0) bad = 1'h1;
        end
        cmp("discharge length", ed ? DIS : 0, len);
        cmp("data_sw_on in discharge", 0, bad);
    endtask
    task automatic t_discharge;
        move(3'h6, 1'h0);
        move(3'h7, 1'h0);
        move(3'h0, 1'h1);
        move(3'h1, 1'h0);
        move(3'h2, 1'h1);
    endtask
    task automatic t_ocur;
        set_mode(3'h7, 1'h1);
        @(posedge mclk);
        overcurrent <= 1'h1;
        attached <= 1'h1;
        repeat (10) @(posedge mclk);
        cmp("data_sw_on", 1, data_sw_on);
        cmp("fault_n", 0, fault_n);
        set_mode(3'h6, 1'h1);
        cmp("fault_n", 1, fault_n);
        cmp("data_sw_on", 1, data_sw_on);
        overcurrent <= 1'h0;
        attached <= 1'h0;
    endtask
    task automatic t_dcp;
        int n = 0;
        set_mode(3'h0, 1'h1);
        cmp("high_bias_scheme", 1, high_bias_scheme);
        attached <= 1'h1;
        repeat (30) @(posedge mclk);
        cmp("high_bias_scheme", 1, high_bias_scheme);
        axi_rd(4'h4, 32'h3, 32'h0, 2'h0);
        attached <= 1'h0;
        repeat (10) @(posedge mclk);
        attached <= 1'h1;
        is_bc12 <= 1'h1;
        for (n = 0; brief_12v_on !== 1'h1 && n < 50; n++)
            @(posedge mclk);
        tmo(n);
        cmp("power in brief", 3'h5, {pwr_sw_on, discharge_on, dline_short_on});
        for (n = 0; brief_12v_on === 1'h1 && n < 50; n++)
            @(posedge mclk);
        cmp("brief length", 1, n == BRIEF || n == BRIEF + 1);
        repeat (20) @(posedge mclk);
        cmp("shorted", 3'h4, {dline_short_on, high_bias_scheme, data_sw_on});
        axi_rd(4'h4, 32'h3, 32'h2, 2'h0);
        axi_wr(4'h0, 32'h3, 2'h0);
        repeat (2) @(posedge mclk);
        cmp("rescan brief", 1, brief_12v_on);
        attached <= 1'h0;
        repeat (20) @(posedge mclk);
        cmp("released", 2'h2, {high_bias_scheme, dline_short_on});
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        cmp("reset outputs", 0, {pwr_sw_on, data_sw_on, discharge_on, dline_short_on});
        arst_n <= 1'h1;
        t_regs;
        t_modes;
        t_enable;
        t_discharge;
        t_ocur;
        t_dcp;
        stop_test;
    end
endmodule
`default_nettype wire
